// ---- bench/pgo_regs_tb_top.sv ----
// self-checking bench for the per-channel gain and offset register bank
`define CHK(got, exp) \
   begin \
      totalChecks++; \
      if ((got) !== (exp)) \
      begin \
         nFail++; \
         $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
      end \
   end

module pgo_regs_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import pgo_pkg::*;

   typedef struct {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wr;
      logic [DATA_W-1:0] rd;
   } pgo_row_t;

   // clock and reset
   logic                                clk;
   logic                                rst_b;
   // register port
   logic [ADDR_W-1:0]                   regAddr;
   logic [DATA_W-1:0]                   regWrData;
   logic                                regWrStrobe;
   logic                                regRdStrobe;
   logic [DATA_W-1:0]                   regRdData;
   // samples
   logic [CHAN_COUNT-1:0][SAMPLE_W-1:0] sampleIn;
   logic                                sampleInValid;
   logic [CHAN_COUNT-1:0][SAMPLE_W-1:0] sampleOut;
   logic                                sampleOutValid;
   // status
   logic                                sampleScaleEnable;
   logic                                sampleShiftEnable;
   logic [CHAN_COUNT-1:0]               mirrorMismatch;
   int                                  nFail;
   int                                  totalChecks;

   // write, read back, expected read value; last row is unmapped
   pgo_row_t rows [8] = '{'{8'h0d, 16'hffff, 16'hfbff}, '{8'h0e, 16'hffff, 16'h03ff},
                          '{8'h0f, 16'h2803, 16'h2803}, '{8'h10, 16'h0003, 16'h0003},
                          '{8'h11, 16'ha9ff, 16'ha9ff}, '{8'h12, 16'hfc55, 16'h0055},
                          '{8'h03, 16'hffff, 16'h1100}, '{8'h20, 16'hffff, 16'h0000}};
   logic [GAIN_W-1:0]  gains [3] = '{5'h1f, 5'h05, 5'h15};
   logic [SHIFT_W-1:0] shifts [3] = '{10'h3ff, 10'h003, 10'h1ff};
   logic [DATA_W-1:0]  modes [4] = '{16'h0000, 16'h1000, 16'h0100, 16'h1100};
   logic [ADDR_W-1:0]  idleAddrs [8] = '{8'h03, 8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h11, 8'h12, 8'h30};
   logic [CHAN_COUNT-1:0][SAMPLE_W-1:0] vecs [3] = '{{14'h0400, 14'h0400, 14'h0400},
                                                    {14'h0000, 14'h2000, 14'h1fff},
                                                    {14'h3000, 14'h3ff0, 14'h0123}};

   pgo_regs u_pgo_regs (
      .clk               (clk),
      .rst_b             (rst_b),
      .regAddr           (regAddr),
      .regWrData         (regWrData),
      .regWrStrobe       (regWrStrobe),
      .regRdStrobe       (regRdStrobe),
      .regRdData         (regRdData),
      .sampleIn          (sampleIn),
      .sampleInValid     (sampleInValid),
      .sampleOut         (sampleOut),
      .sampleOutValid    (sampleOutValid),
      .sampleScaleEnable (sampleScaleEnable),
      .sampleShiftEnable (sampleShiftEnable),
      .mirrorMismatch    (mirrorMismatch)
   );

   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // gain in 0.2 dB steps, floor, signed offset, saturate to 14 bits
   function automatic logic [SAMPLE_W-1:0] expOut(input logic [SAMPLE_W-1:0] s,
      input logic [GAIN_W-1:0] g, input logic [SHIFT_W-1:0] o, input logic sc, input logic sh);
      longint lut;
      longint p;
      lut = sc ? longint'($rtoi(4096.0 * (10.0 ** (real'(g) / 100.0)) + 0.5)) : 64'sd4096;
      p = (longint'(signed'(s)) * lut) >>> 12;
      p = p + (sh ? longint'(signed'(o)) : 64'sd0);
      if (p > 8191) p = 8191;
      if (p < -8192) p = -8192;
      return p[SAMPLE_W-1:0];
   endfunction

   // optional write, then read on the next cycle with no gap
   task automatic access(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] w,
                         input logic doWr, input logic [DATA_W-1:0] exp);
      @(posedge clk);
      regAddr <= a;
      regWrData <= w;
      regWrStrobe <= doWr;
      regRdStrobe <= !doWr;
      if (doWr)
      begin
         @(posedge clk);
         regWrStrobe <= 1'b0;
         regRdStrobe <= 1'b1;
      end
      @(posedge clk);
      regRdStrobe <= 1'b0;
      #1 `CHK(regRdData, exp)
      @(posedge clk);
      #1 `CHK(regRdData, WORD_ZERO)
   endtask

   task automatic sendCheck(input logic [CHAN_COUNT-1:0][SAMPLE_W-1:0] v,
                            input logic sc, input logic sh);
      @(posedge clk);
      sampleIn <= v;
      sampleInValid <= 1'b1;
      @(posedge clk);
      sampleInValid <= 1'b0;
      #1 `CHK(sampleOutValid, 1'b1)
      for (int c = 0; c < CHAN_COUNT; c++)
         `CHK(sampleOut[c], expOut(v[c], gains[c], shifts[c], sc, sh))
      @(posedge clk);
      #1 `CHK(sampleOutValid, 1'b0)
      `CHK(sampleOut[2], expOut(v[2], gains[2], shifts[2], sc, sh))
   endtask

   task automatic checkIdle();
      `CHK(sampleOut, '0)
      `CHK({sampleOutValid, sampleScaleEnable, sampleShiftEnable, mirrorMismatch}, 6'h00)
      foreach (idleAddrs[i])
         access(idleAddrs[i], WORD_ZERO, 1'b0, WORD_ZERO);
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", totalChecks, nFail);
      if (nFail == 0 && totalChecks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   initial
   begin
      nFail = 0;
      totalChecks = 0;
      rst_b = 1'b0;
      regAddr = '0;
      regWrData = '0;
      regWrStrobe = 1'b0;
      regRdStrobe = 1'b0;
      sampleIn = '0;
      sampleInValid = 1'b0;
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      #1 checkIdle();
      foreach (rows[i])
         access(rows[i].addr, rows[i].wr, 1'b1, rows[i].rd);
      `CHK(mirrorMismatch, 3'h4)
      access(ADDR_MIRROR_STATUS, WORD_ZERO, 1'b0, 16'h0004);
      access(ADDR_CHAN3_OFFSET_MIRROR, 16'h01ff, 1'b1, 16'h01ff);
      `CHK(mirrorMismatch, 3'h0)
      foreach (modes[m])
      begin
         access(ADDR_CTRL3, modes[m], 1'b1, modes[m]);
         `CHK({sampleScaleEnable, sampleShiftEnable}, {modes[m][12], modes[m][8]})
         foreach (vecs[v])
            sendCheck(vecs[v], modes[m][12], modes[m][8]);
      end
      // reset in mid-run clears every field again
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      #1 checkIdle();
      conclude();
   end

   // bounded run length
   initial
   begin
      repeat (20000) @(posedge clk);
      nFail++;
      conclude();
   end
endmodule

// ---- logic/pgo_chan_path.sv ----
// one channel's digital gain and offset sample path
module pgo_chan_path
   import pgo_pkg::*;
(
   // clock and reset
   input  wire logic                clk,
   input  wire logic                rst_b,
   // settings
   input  wire logic                scaleEnable,
   input  wire logic                shiftEnable,
   input  wire logic [GAIN_W-1:0]   gainCode,
   input  wire logic [SHIFT_W-1:0]  dcShift,
   // samples
   input  wire logic [SAMPLE_W-1:0] sampleIn,
   input  wire logic                sampleValid,
   output logic      [SAMPLE_W-1:0] sampleOut
);
   // gain factors 10^(n*0.2/20) in 4.12 fixed point
   localparam logic [LUT_W-1:0] GAIN_LUT [2**GAIN_W] = '{
      16'h1000, 16'h105f, 16'h10c1, 16'h1125, 16'h118b, 16'h11f4, 16'h125f, 16'h12cc,
      16'h133c, 16'h13af, 16'h1425, 16'h149d, 16'h1518, 16'h1595, 16'h1616, 16'h169a,
      16'h1720, 16'h17aa, 16'h1838, 16'h18c8, 16'h195c, 16'h19f3, 16'h1a8e, 16'h1b2c,
      16'h1bce, 16'h1c74, 16'h1d1d, 16'h1dcb, 16'h1e7d, 16'h1f32, 16'h1fed, 16'h20ab};

   logic        [LUT_W-1:0]    gainFactor;
   logic signed [PROD_W-1:0]   product;
   logic signed [PROD_W-1:0]   scaled;
   logic signed [PROD_W-1:0]   shiftTerm;
   logic signed [PROD_W-1:0]   sum;
   logic        [SAMPLE_W-1:0] sampleOut_next;
   logic        [SAMPLE_W-1:0] sampleOut_reg;

   assign gainFactor = scaleEnable ? GAIN_LUT[gainCode] : GAIN_UNITY;
   assign product    = $signed(sampleIn) * $signed({1'b0, gainFactor});
   assign scaled     = product >>> GAIN_FRAC;
   assign shiftTerm  = shiftEnable ? PROD_W'($signed(dcShift)) : '0;
   assign sum        = scaled + shiftTerm;
   assign sampleOut_next = (sum > PROD_W'(SAMPLE_MAX)) ? SAMPLE_MAX :
                           (sum < PROD_W'(SAMPLE_MIN)) ? SAMPLE_MIN :
                           sum[SAMPLE_W-1:0];

   always_ff @(posedge clk)
   begin
      if (!rst_b)
         sampleOut_reg <= SAMPLE_ZERO;
      else if (sampleValid)
         sampleOut_reg <= sampleOut_next;
   end

   assign sampleOut = sampleOut_reg;

   // checks
   localparam logic [GAIN_W-1:0]   CHK_CODE   = 5'h05;
   localparam logic [SAMPLE_W-1:0] CHK_IN     = 14'h0400;
   localparam logic [SAMPLE_W-1:0] CHK_OUT    = 14'h047d;
   localparam logic [SHIFT_W-1:0]  CHK_MINUS1 = 10'h3ff;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   gain_step_a: assert property (
      sampleValid && scaleEnable && !shiftEnable && gainCode == CHK_CODE && sampleIn == CHK_IN
      |=> sampleOut == CHK_OUT)
      else $error("gain code 5 did not scale 1024 to 1149");
   scale_gate_a: assert property (
      sampleValid && !scaleEnable && !shiftEnable && gainCode != GAIN_RESET
      |=> sampleOut == $past(sampleIn))
      else $error("gain applied while scale disabled");
   shift_signed_a: assert property (
      sampleValid && shiftEnable && !scaleEnable && dcShift == CHK_MINUS1
      && $signed(sampleIn) != SAMPLE_MIN
      |=> $signed(sampleOut) == $signed($past(sampleIn)) - 1)
      else $error("offset of all ones did not subtract one");
   shift_gate_a: assert property (
      sampleValid && !shiftEnable && !scaleEnable && dcShift != SHIFT_RESET
      |=> sampleOut == $past(sampleIn))
      else $error("offset applied while shift disabled");
   pass_hold_a: assert property (
      !sampleValid |=> $stable(sampleOut))
      else $error("output changed without a valid sample");
endmodule

// ---- logic/pgo_regs.sv ----
// per-channel gain and offset register bank with sample path
//
// Design decision made here: the strobed register port.
module pgo_regs
   import pgo_pkg::*;
(
   // clock and reset
   input  wire logic                                clk,
   input  wire logic                                rst_b,
   // register port
   input  wire logic [ADDR_W-1:0]                   regAddr,
   input  wire logic [DATA_W-1:0]                   regWrData,
   input  wire logic                                regWrStrobe,
   input  wire logic                                regRdStrobe,
   output logic      [DATA_W-1:0]                   regRdData,
   // samples in
   input  wire logic [CHAN_COUNT-1:0][SAMPLE_W-1:0] sampleIn,
   input  wire logic                                sampleInValid,
   // samples out
   output logic      [CHAN_COUNT-1:0][SAMPLE_W-1:0] sampleOut,
   output logic                                     sampleOutValid,
   // status
   output logic                                     sampleScaleEnable,
   output logic                                     sampleShiftEnable,
   output logic      [CHAN_COUNT-1:0]               mirrorMismatch
);
   localparam logic [ADDR_W-1:0] GAIN_OFFSET_ADDR [CHAN_COUNT] = '{
      ADDR_CHAN1_GAIN_OFFSET, ADDR_CHAN2_GAIN_OFFSET, ADDR_CHAN3_GAIN_OFFSET};
   localparam logic [ADDR_W-1:0] OFFSET_MIRROR_ADDR [CHAN_COUNT] = '{
      ADDR_CHAN1_OFFSET_MIRROR, ADDR_CHAN2_OFFSET_MIRROR, ADDR_CHAN3_OFFSET_MIRROR};

   function automatic logic [DATA_W-1:0] packGainOffset(
      input logic [GAIN_W-1:0]  g,
      input logic [SHIFT_W-1:0] s);
      logic [DATA_W-1:0] w;
      w = WORD_ZERO;
      w[GAIN_MSB:GAIN_LSB]   = g;
      w[SHIFT_MSB:SHIFT_LSB] = s;
      return w;
   endfunction

   function automatic logic hit(
      input logic              strobe,
      input logic [ADDR_W-1:0] a,
      input logic [ADDR_W-1:0] target);
      return strobe && (a == target);
   endfunction

   logic                  scaleEnable_reg;
   logic                  shiftEnable_reg;
   logic [GAIN_W-1:0]     gainCode_reg [CHAN_COUNT];
   logic [SHIFT_W-1:0]    dcShift_reg [CHAN_COUNT];
   logic [SHIFT_W-1:0]    shiftMirror_reg [CHAN_COUNT];
   logic [CHAN_COUNT-1:0] mismatch_reg;
   logic [CHAN_COUNT-1:0] mismatch_next;
   logic                  outValid_reg;
   logic [DATA_W-1:0]     rdData_reg;
   logic [DATA_W-1:0]     rdData_next;
   logic [DATA_W-1:0]     chanRead [CHAN_COUNT];
   logic [DATA_W-1:0]     ctrlRead;
   logic [DATA_W-1:0]     statusRead;
   logic                  ctrlWrite;

   // control register 3 enables
   assign ctrlWrite = hit(regWrStrobe, regAddr, ADDR_CTRL3);

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         scaleEnable_reg <= 1'b0;
         shiftEnable_reg <= 1'b0;
      end
      else if (ctrlWrite)
      begin
         scaleEnable_reg <= regWrData[SCALE_EN_BIT];
         shiftEnable_reg <= regWrData[SHIFT_EN_BIT];
      end
   end

   // per-channel registers and sample path
   for (genvar c = 0; c < CHAN_COUNT; c++)
   begin : g_chan
      logic gainWrite;
      logic mirrorWrite;

      assign gainWrite   = hit(regWrStrobe, regAddr, GAIN_OFFSET_ADDR[c]);
      assign mirrorWrite = hit(regWrStrobe, regAddr, OFFSET_MIRROR_ADDR[c]);

      always_ff @(posedge clk)
      begin
         if (!rst_b)
         begin
            gainCode_reg[c]    <= GAIN_RESET;
            dcShift_reg[c]     <= SHIFT_RESET;
            shiftMirror_reg[c] <= SHIFT_RESET;
         end
         else
         begin
            if (gainWrite)
            begin
               gainCode_reg[c] <= regWrData[GAIN_MSB:GAIN_LSB];
               dcShift_reg[c]  <= regWrData[SHIFT_MSB:SHIFT_LSB];
            end
            if (mirrorWrite)
               shiftMirror_reg[c] <= regWrData[SHIFT_MSB:SHIFT_LSB];
         end
      end

      assign mismatch_next[c] = dcShift_reg[c] != shiftMirror_reg[c];

      // reads of either register of this channel; reserved bits return zero
      assign chanRead[c] =
         (regAddr == GAIN_OFFSET_ADDR[c]) ? packGainOffset(gainCode_reg[c], dcShift_reg[c]) :
         (regAddr == OFFSET_MIRROR_ADDR[c]) ? packGainOffset(GAIN_RESET, shiftMirror_reg[c]) :
         WORD_ZERO;

      pgo_chan_path u_path (
         .clk         (clk),
         .rst_b       (rst_b),
         .scaleEnable (scaleEnable_reg),
         .shiftEnable (shiftEnable_reg),
         .gainCode    (gainCode_reg[c]),
         .dcShift     (dcShift_reg[c]),
         .sampleIn    (sampleIn[c]),
         .sampleValid (sampleInValid),
         .sampleOut   (sampleOut[c])
      );
   end

   // read data, one cycle after the strobe, zero for unmapped addresses
   assign ctrlRead   = (regAddr == ADDR_CTRL3) ?
                       ((DATA_W'(scaleEnable_reg) << SCALE_EN_BIT) |
                        (DATA_W'(shiftEnable_reg) << SHIFT_EN_BIT)) : WORD_ZERO;
   assign statusRead = (regAddr == ADDR_MIRROR_STATUS) ? DATA_W'(mismatch_reg) : WORD_ZERO;

   always_comb
   begin
      rdData_next = ctrlRead | statusRead;
      for (int c = 0; c < CHAN_COUNT; c++)
         rdData_next = rdData_next | chanRead[c];
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         rdData_reg   <= WORD_ZERO;
         mismatch_reg <= '0;
         outValid_reg <= 1'b0;
      end
      else
      begin
         rdData_reg   <= regRdStrobe ? rdData_next : WORD_ZERO;
         mismatch_reg <= mismatch_next;
         outValid_reg <= sampleInValid;
      end
   end

   assign regRdData         = rdData_reg;
   assign sampleOutValid    = outValid_reg;
   assign sampleScaleEnable = scaleEnable_reg;
   assign sampleShiftEnable = shiftEnable_reg;
   assign mirrorMismatch    = mismatch_reg;

   // checks
   localparam logic [DATA_W-1:0] CHK_ONES        = 16'hffff;
   localparam logic [DATA_W-1:0] CHK_MIRROR_READ = 16'h03ff;

   logic [GAIN_W-1:0] wrGainField;
   assign wrGainField = regWrData[GAIN_MSB:GAIN_LSB];

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   sequence mirrorOnesWrite;
      regWrStrobe && regAddr == ADDR_CHAN1_OFFSET_MIRROR && regWrData == CHK_ONES;
   endsequence

   sequence mirrorReadBack;
      regRdStrobe && regAddr == ADDR_CHAN1_OFFSET_MIRROR;
   endsequence

   mirror_reserved_a: assert property (
      mirrorOnesWrite ##1 mirrorReadBack |=> regRdData == CHK_MIRROR_READ)
      else $error("mirror register reserved bits not zero");
   chan2_gain_a: assert property (
      regWrStrobe && regAddr == ADDR_CHAN2_GAIN_OFFSET
      |=> gainCode_reg[1] == $past(wrGainField) && gainCode_reg[0] == $past(gainCode_reg[0]))
      else $error("channel 2 gain code not taken from its register");
   reset_zero_a: assert property (
      $rose(rst_b) |-> regRdData == WORD_ZERO && !sampleScaleEnable && !sampleShiftEnable
      && gainCode_reg[0] == GAIN_RESET && dcShift_reg[2] == SHIFT_RESET
      && mirrorMismatch == '0)
      else $error("fields not zero after reset");

   sequence chan3GainWrite;
      regWrStrobe && regAddr == ADDR_CHAN3_GAIN_OFFSET;
   endsequence

   chan3_gain_a: assert property (
      chan3GainWrite |=> gainCode_reg[2] == $past(wrGainField)
      && gainCode_reg[1] == $past(gainCode_reg[1]))
      else $error("channel 3 gain code not taken from its register");
   scale_enable_a: assert property (
      ctrlWrite |=> sampleScaleEnable == $past(regWrData[SCALE_EN_BIT]))
      else $error("scale enable not taken from control bit");
   shift_enable_a: assert property (
      ctrlWrite |=> sampleShiftEnable == $past(regWrData[SHIFT_EN_BIT]))
      else $error("shift enable not taken from control bit");
   mirror_upper_a: assert property (
      regRdStrobe && regAddr == ADDR_CHAN3_OFFSET_MIRROR
      |=> regRdData[DATA_W-1:SHIFT_MSB+1] == '0)
      else $error("mirror register upper bits read nonzero");
endmodule

// ---- pkg/pgo_pkg.sv ----
// constants for the per-channel gain and offset register bank
package pgo_pkg;
   localparam int ADDR_W     = 8;
   localparam int DATA_W     = 16;
   localparam int SAMPLE_W   = 14;
   localparam int CHAN_COUNT = 3;
   localparam int GAIN_W     = 5;
   localparam int SHIFT_W    = 10;
   localparam int LUT_W      = 16;
   localparam int GAIN_FRAC  = 12;
   localparam int PROD_W     = SAMPLE_W + LUT_W + 1;
   localparam int GAIN_STEP_MILLIDB = 200;

   // register offsets
   localparam logic [ADDR_W-1:0] ADDR_CTRL3               = 8'h03;
   localparam logic [ADDR_W-1:0] ADDR_CHAN1_GAIN_OFFSET   = 8'h0d;
   localparam logic [ADDR_W-1:0] ADDR_CHAN1_OFFSET_MIRROR = 8'h0e;
   localparam logic [ADDR_W-1:0] ADDR_CHAN2_GAIN_OFFSET   = 8'h0f;
   localparam logic [ADDR_W-1:0] ADDR_CHAN2_OFFSET_MIRROR = 8'h10;
   localparam logic [ADDR_W-1:0] ADDR_CHAN3_GAIN_OFFSET   = 8'h11;
   localparam logic [ADDR_W-1:0] ADDR_CHAN3_OFFSET_MIRROR = 8'h12;
   localparam logic [ADDR_W-1:0] ADDR_MIRROR_STATUS       = 8'h30;

   // field positions
   localparam int SCALE_EN_BIT = 12;
   localparam int SHIFT_EN_BIT = 8;
   localparam int GAIN_MSB     = 15;
   localparam int GAIN_LSB     = 11;
   localparam int SHIFT_MSB    = 9;
   localparam int SHIFT_LSB    = 0;

   // reset values
   localparam logic [GAIN_W-1:0]   GAIN_RESET  = 5'h00;
   localparam logic [SHIFT_W-1:0]  SHIFT_RESET = 10'h000;
   localparam logic [DATA_W-1:0]   WORD_ZERO   = 16'h0000;
   localparam logic [SAMPLE_W-1:0] SAMPLE_ZERO = 14'h0000;

   // sample limits and unity gain
   localparam logic signed [SAMPLE_W-1:0] SAMPLE_MAX = 14'sh1fff;
   localparam logic signed [SAMPLE_W-1:0] SAMPLE_MIN = 14'sh2000;
   localparam logic [LUT_W-1:0]           GAIN_UNITY = 16'h1000;
endpackage
